// *** tb/sipm_tb_top.sv ***
// Self-checking bench of the spectral interrupt and matrix command block
`timescale 1ns/1ps
module sipm_tb_top;
  logic                    hclk;
  logic                    hresetn;
  logic                    hsel;
  logic [31:0]             haddr;
  logic [1:0]              htrans;
  logic                    hwrite;
  logic [2:0]              hsize;
  logic [31:0]             hwdata;
  logic [31:0]             hrdata;
  logic                    hreadyout;
  logic                    hresp;
  sipm_pkg::sipm_sample_t  sample;
  logic                    flicker_status;
  sipm_pkg::sipm_mux_cmd_t matrix_cmd;
  logic                    matrix_chain_done;
  logic                    irq;
  int                      n_mismatch;
  int                      checks_done;
  logic [15:0]             lfsr;
  logic [31:0]             rd;
  logic [3:0]              code;
  logic [3:0]              got;
  logic                    en;
  logic                    fired;
  int                      t;
  int                      cnt;
  int                      sel;

  sipm_top sipm_top_inst (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .sample            (sample),
    .flicker_status    (flicker_status),
    .matrix_cmd        (matrix_cmd),
    .matrix_chain_done (matrix_chain_done),
    .irq               (irq)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic int exp_target(input logic [3:0] c);
    if (c == 4'h0) exp_target = 1;
    else if (c < 4'h4) exp_target = int'(c);
    else exp_target = 5 * (int'(c) - 3);
  endfunction : exp_target

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // Holds the current phase until hready is seen high at a falling edge, then returns after the next rising edge
  task automatic wait_ready;
    logic ok;
    ok = 1'b0;
    while (!ok) begin
      @(negedge hclk);
      ok = (hreadyout === 1'b1);
      rd = hrdata;
      @(posedge hclk);
    end
  endtask : wait_ready

  // Single word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_ready;
  endtask : ahb

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string name);
    ahb(1'b0, idx, 32'h0);
    chk(name, exp, rd);
  endtask : rd_chk

  task automatic chk_irq(input logic e);
    @(negedge hclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge hclk);
  endtask : chk_irq

  // One sample; other channels random, selected channel in or out of window
  task automatic send(input logic out);
    sipm_pkg::sipm_sample_t s;
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_next(lfsr);
      s.ch[k] = lfsr;
    end
    lfsr = lfsr_next(lfsr);
    if (!out) s.ch[sel] = lfsr[12] ? 16'h2000 : 16'h1000 + {4'h0, lfsr[11:0]};
    else s.ch[sel] = lfsr[0] ? {4'h0, lfsr[11:0]} : 16'h2001 + {4'h0, lfsr[11:0]};
    s.valid = 1'b1;
    if (out) cnt++;
    else cnt = 0;
    if (code == 4'h0 || (out && cnt >= t)) fired = 1'b1;
    sample <= s;
    @(posedge hclk);
    sample.valid <= 1'b0;
    @(posedge hclk);
    chk_irq(fired);
  endtask : send

  initial begin
    #300000;
    n_mismatch++;
    final_report;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sample = '0;
    flicker_status = 1'b0;
    matrix_chain_done = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    // Seed 9209
    lfsr = 16'h23F9;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(sipm_pkg::IDX_MUX_CMD_CONFIG, 32'h10, "mux_cfg_rst");
    rd_chk(sipm_pkg::IDX_SYS_IRQ_ENABLE, 32'h0, "sys_en_rst");
    rd_chk(sipm_pkg::IDX_IRQ_PERSISTENCE, 32'h0, "irq_persistence_rst");
    rd_chk(sipm_pkg::IDX_HIGH_THRESHOLD, 32'hFFFF, "high_th_rst");
    rd_chk(sipm_pkg::IDX_IRQ_MASK, 32'h0, "mask_rst");
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'h0, "unmapped");
    // Matrix commands, completion interrupt enabled except for code 1
    for (int c = 0; c < 3; c++) begin
      en = (c != 1);
      ahb(1'b1, sipm_pkg::IDX_SYS_IRQ_ENABLE, {27'h0, en, 4'h0});
      ahb(1'b1, sipm_pkg::IDX_IRQ_MASK, 32'h1);
      ahb(1'b1, sipm_pkg::IDX_MUX_CMD_CONFIG, 32'(c) << 3);
      rd_chk(sipm_pkg::IDX_MUX_CMD_CONFIG, 32'(c) << 3, "mux_cfg");
      ahb(1'b1, sipm_pkg::IDX_SPECTRAL_CTRL, 32'h10);
      got = 4'h0;
      for (int i = 0; i < 8 && got[3] !== 1'b1; i++) begin
        @(negedge hclk);
        got = matrix_cmd;
        @(posedge hclk);
      end
      chk("matrix_cmd", {28'h0, 1'b1, c == 0, c == 1, c == 2}, {28'h0, got});
      rd_chk(sipm_pkg::IDX_SPECTRAL_CTRL, 32'h10, "kick_busy");
      matrix_chain_done <= 1'b1;
      @(posedge hclk);
      matrix_chain_done <= 1'b0;
      repeat (3) @(posedge hclk);
      rd_chk(sipm_pkg::IDX_SPECTRAL_CTRL, 32'h0, "kick_done");
      rd_chk(sipm_pkg::IDX_IRQ_STATUS, {31'h0, en}, "mux_done_st");
      chk_irq(en);
      ahb(1'b1, sipm_pkg::IDX_IRQ_STATUS, 32'h1);
      chk_irq(1'b0);
    end
    // Flicker change with enable set, then clear
    for (int e = 1; e >= 0; e--) begin
      ahb(1'b1, sipm_pkg::IDX_IRQ_MASK, 32'h2);
      ahb(1'b1, sipm_pkg::IDX_SYS_IRQ_ENABLE, e ? 32'h40 : 32'h0);
      flicker_status <= ~flicker_status;
      repeat (2) @(posedge hclk);
      rd_chk(sipm_pkg::IDX_IRQ_STATUS, e ? 32'h2 : 32'h0, "flicker_st");
      chk_irq(e[0]);
      ahb(1'b1, sipm_pkg::IDX_IRQ_MASK, 32'h0);
      chk_irq(1'b0);
      ahb(1'b1, sipm_pkg::IDX_IRQ_STATUS, 32'h2);
    end
    // Persistence filter over every code
    ahb(1'b1, sipm_pkg::IDX_LOW_THRESHOLD, 32'h1000);
    ahb(1'b1, sipm_pkg::IDX_HIGH_THRESHOLD, 32'h2000);
    ahb(1'b1, sipm_pkg::IDX_IRQ_MASK, 32'h4);
    for (int c = 0; c < 16; c++) begin
      code = 4'(c);
      t = exp_target(code);
      lfsr = lfsr_next(lfsr);
      sel = int'(lfsr % 16'h6);
      ahb(1'b1, sipm_pkg::IDX_SPECTRAL_CTRL, {28'h0, 3'(sel), 1'b1});
      ahb(1'b1, sipm_pkg::IDX_IRQ_PERSISTENCE, {28'h0, code});
      ahb(1'b1, sipm_pkg::IDX_IRQ_STATUS, 32'h4);
      cnt = 0;
      fired = 1'b0;
      repeat (t - 1) send(1'b1);
      if (c % 2 == 1) begin
        ahb(1'b1, sipm_pkg::IDX_SPECTRAL_CTRL, {28'h0, 3'(sel), 1'b0});
        ahb(1'b1, sipm_pkg::IDX_SPECTRAL_CTRL, {28'h0, 3'(sel), 1'b1});
      end
      else ahb(1'b1, sipm_pkg::IDX_IRQ_PERSISTENCE, {28'h0, code});
      cnt = 0;
      repeat (t - 1) send(1'b1);
      send(1'b0);
      repeat (t) send(1'b1);
      rd_chk(sipm_pkg::IDX_IRQ_STATUS, 32'h4, "irq_persistence_status");
    end
    chk("hresp", 32'h0, {31'h0, hresp});
    final_report;
  end
endmodule : sipm_tb_top

// *** verilog/sipm_irq_persistence_filter.sv ***
// Persistence filter on the selected spectral channel
`timescale 1ns/1ps
module sipm_irq_persistence_filter (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Sample and configuration
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic [15:0] low_th,
  input  wire logic [15:0] high_th,
  input  wire logic [3:0]  irq_persistence_code,
  input  wire logic        clear,
  // Result
  output logic             irq_persistence_irq
);

  logic [5:0] count_reg;
  logic [5:0] count_next;

  wire logic [5:0] target  = sipm_pkg::irq_persistence_target(irq_persistence_code);
  wire logic       outside = sipm_pkg::outside_window(sample_data, low_th, high_th);
  wire logic [5:0] count_inc = (count_reg == 6'h3F) ? count_reg : 6'(count_reg + 6'h01);

  always_comb begin
    count_next = count_reg;
    if (clear) count_next = 6'h00;
    else if (sample_valid && outside) count_next = count_inc;
    else if (sample_valid) count_next = 6'h00;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) count_reg <= 6'h00;
    else count_reg <= count_next;
  end

  // Code zero fires on every spectral cycle
  assign irq_persistence_irq = !clear && sample_valid &&
                    ((irq_persistence_code == 4'h0) || (outside && count_inc >= target));

  inside_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sample_valid && !outside) |=> (count_reg == 6'h00))
    else $error("in-window sample did not clear the count");

  clear_zeroes_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clear |=> (count_reg == 6'h00) && !$past(irq_persistence_irq))
    else $error("clear did not zero the count");

  fire_needs_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_persistence_irq && irq_persistence_code != 4'h0) |=> (count_reg >= $past(target)) && $past(outside))
    else $error("persistence interrupt before run length reached");

  code15_sixty_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_persistence_code == 4'hF) |-> (target == 6'd60))
    else $error("persistence code 15 does not need 60 samples");

endmodule : sipm_irq_persistence_filter

// *** verilog/sipm_mux_seq.sv ***
// Switch-matrix command sequencer: decode, launch and completion
`timescale 1ns/1ps
module sipm_mux_seq (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // Control
  input  wire logic                   kick,
  input  wire logic [1:0]             cmd,
  input  wire logic                   chain_done,
  // Results
  output sipm_pkg::sipm_mux_cmd_t     mux_cmd,
  output logic                        done,
  output logic                        busy
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN  = 3'b010,
    S_DONE = 3'b100
  } sipm_seq_state_t;

  sipm_seq_state_t          state_reg;
  sipm_seq_state_t          state_next;
  sipm_pkg::sipm_mux_cmd_t  cmd_reg;
  sipm_pkg::sipm_mux_cmd_t  cmd_next;

  wire logic launch = (state_reg == S_IDLE) && kick;
  wire logic legal  = (cmd != sipm_pkg::CMD_RESERVED);

  always_comb begin
    state_next = state_reg;
    cmd_next   = '0;
    case (state_reg)
      S_IDLE: begin
        if (launch) begin
          if (legal) begin
            state_next           = S_RUN;
            cmd_next.start       = 1'b1;
            cmd_next.load_rom    = (cmd == sipm_pkg::CMD_ROM_INIT);
            cmd_next.copy_to_ram = (cmd == sipm_pkg::CMD_READ_RAM);
            cmd_next.shift_out   = (cmd == sipm_pkg::CMD_WRITE_RAM);
          end else begin
            state_next = S_DONE;
          end
        end
      end
      S_RUN: begin
        if (chain_done) state_next = S_DONE;
      end
      S_DONE:  state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      cmd_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
    end
  end

  assign mux_cmd = cmd_reg;
  assign done    = (state_reg == S_DONE);
  assign busy    = (state_reg != S_IDLE);

  kick_starts_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == S_IDLE && kick && legal) |=> (mux_cmd.start && state_reg == S_RUN))
    else $error("kick did not start a matrix command");

  one_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mux_cmd.start |-> $onehot({mux_cmd.load_rom, mux_cmd.copy_to_ram, mux_cmd.shift_out})
      && (mux_cmd.shift_out == ($past(cmd) == sipm_pkg::CMD_WRITE_RAM)))
    else $error("matrix command strobe does not match code");

endmodule : sipm_mux_seq

// *** verilog/sipm_pkg.sv ***
// Shared constants, types and helper functions of the spectral interrupt block
package sipm_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_MUX_CMD_CONFIG  = 8'hAF;
  localparam logic [7:0] IDX_SYS_IRQ_ENABLE  = 8'hB2;
  localparam logic [7:0] IDX_IRQ_PERSISTENCE = 8'hBD;
  localparam logic [7:0] IDX_IRQ_STATUS      = 8'hC0;
  localparam logic [7:0] IDX_IRQ_MASK        = 8'hC1;
  localparam logic [7:0] IDX_LOW_THRESHOLD   = 8'hC2;
  localparam logic [7:0] IDX_HIGH_THRESHOLD  = 8'hC3;
  localparam logic [7:0] IDX_SPECTRAL_CTRL   = 8'hC4;

  // Field positions
  localparam int MUX_CMD_LSB     = 3;
  localparam int MUX_CMD_MSB     = 4;
  localparam int SIEN_MUX_BIT    = 4;
  localparam int FLICKER_CHANGE_IRQ_ENABLE_BIT     = 6;
  localparam int IRQ_PERSISTENCE_MSB        = 3;
  localparam int CTRL_SP_EN_BIT  = 0;
  localparam int CTRL_CH_LSB     = 1;
  localparam int CTRL_CH_MSB     = 3;
  localparam int CTRL_KICK_BIT   = 4;
  localparam int ST_MUX_DONE_BIT = 0;
  localparam int ST_FLICKER_BIT  = 1;
  localparam int ST_SPECTRAL_BIT = 2;

  // Reset values
  localparam logic [1:0]  MUX_CMD_RESET   = 2'h2;
  localparam logic [3:0]  IRQ_PERSISTENCE_RESET      = 4'h0;
  localparam logic [15:0] LOW_TH_RESET    = 16'h0000;
  localparam logic [15:0] HIGH_TH_RESET   = 16'hFFFF;

  // Matrix command codes
  localparam logic [1:0] CMD_ROM_INIT  = 2'h0;
  localparam logic [1:0] CMD_READ_RAM  = 2'h1;
  localparam logic [1:0] CMD_WRITE_RAM = 2'h2;
  localparam logic [1:0] CMD_RESERVED  = 2'h3;

  localparam int NUM_CH = 6;

  typedef struct packed {
    logic                  valid;
    logic [NUM_CH-1:0][15:0] ch;
  } sipm_sample_t;

  typedef struct packed {
    logic start;
    logic load_rom;
    logic copy_to_ram;
    logic shift_out;
  } sipm_mux_cmd_t;

  // Consecutive out-of-window samples needed for a given persistence code
  function automatic logic [5:0] irq_persistence_target(input logic [3:0] code);
    logic [5:0] c;
    c = {2'h0, code};
    if (code == 4'h0) irq_persistence_target = 6'h01;
    else if (code <= 4'h3) irq_persistence_target = c;
    else irq_persistence_target = 6'((c - 6'h03) * 6'h05);
  endfunction : irq_persistence_target

  function automatic logic outside_window(input logic [15:0] d, input logic [15:0] lo,
                                          input logic [15:0] hi);
    outside_window = (d < lo) || (d > hi);
  endfunction : outside_window

endpackage : sipm_pkg

// *** verilog/sipm_top.sv ***
// Spectral interrupt qualification and matrix command block with AHB-Lite registers
`timescale 1ns/1ps

// Summary of operation
// - Command field resets to 2, runs on kick
// - Codes: ROM load, chain to RAM, RAM out
// - Matrix done raises interrupt when enabled
// - Flicker status change interrupts when enabled
// - Count out-of-window run, interrupt at target
// - In-window sample resets the count
// - Only the selected channel, or channel 0 for selector 6 or 7, is compared
// - Code maps to 1,1,2,3,5..60 samples
module sipm_top (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Spectral samples and flicker status
  input  wire sipm_pkg::sipm_sample_t sample,
  input  wire logic                 flicker_status,
  // Switch-matrix chain
  output sipm_pkg::sipm_mux_cmd_t   matrix_cmd,
  input  wire logic                 matrix_chain_done,
  // Interrupt
  output logic                      irq
);

  // Register state
  logic [1:0]  mux_cmd_reg;
  logic        sien_mux_reg;
  logic        flicker_change_irq_enable_reg;
  logic [3:0]  irq_persistence_reg;
  logic [2:0]  status_reg;
  logic [2:0]  status_next;
  logic [2:0]  mask_reg;
  logic [15:0] low_th_reg;
  logic [15:0] high_th_reg;
  logic        sp_en_reg;
  logic [2:0]  ch_sel_reg;
  logic        kick_reg;
  logic        kick_next;
  logic        flicker_prev_reg;

  // Bus pipeline state
  logic [9:0]  addr_reg;
  logic        wr_pend_reg;
  logic        rd_wait_reg;
  logic [31:0] hrdata_reg;

  // Sub-block results
  logic        mux_done;
  logic        mux_busy;
  logic        irq_persistence_irq;

  // Address phase
  wire logic addr_phase = hsel && hready && htrans[1];

  // Data-phase hit on one register index; upper index bits must be zero
  function automatic logic reg_hit(input logic [9:0] a, input logic [7:0] want);
    reg_hit = (a[9:8] == 2'h0) && (a[7:0] == want);
  endfunction : reg_hit

  // Register selects for the data phase
  wire logic sel_mux  = reg_hit(addr_reg, sipm_pkg::IDX_MUX_CMD_CONFIG);
  wire logic sel_sien = reg_hit(addr_reg, sipm_pkg::IDX_SYS_IRQ_ENABLE);
  wire logic sel_irq_persistence = reg_hit(addr_reg, sipm_pkg::IDX_IRQ_PERSISTENCE);
  wire logic sel_st   = reg_hit(addr_reg, sipm_pkg::IDX_IRQ_STATUS);
  wire logic sel_mask = reg_hit(addr_reg, sipm_pkg::IDX_IRQ_MASK);
  wire logic sel_low  = reg_hit(addr_reg, sipm_pkg::IDX_LOW_THRESHOLD);
  wire logic sel_high = reg_hit(addr_reg, sipm_pkg::IDX_HIGH_THRESHOLD);
  wire logic sel_ctrl = reg_hit(addr_reg, sipm_pkg::IDX_SPECTRAL_CTRL);

  wire logic wr_mux  = wr_pend_reg && sel_mux;
  wire logic wr_sien = wr_pend_reg && sel_sien;
  wire logic wr_irq_persistence = wr_pend_reg && sel_irq_persistence;
  wire logic wr_st   = wr_pend_reg && sel_st;
  wire logic wr_mask = wr_pend_reg && sel_mask;
  wire logic wr_low  = wr_pend_reg && sel_low;
  wire logic wr_high = wr_pend_reg && sel_high;
  wire logic wr_ctrl = wr_pend_reg && sel_ctrl;

  // Read-back words
  wire logic [31:0] rd_mux  = {27'h0, mux_cmd_reg, 3'h0};
  wire logic [31:0] rd_sien = {25'h0, flicker_change_irq_enable_reg, 1'b0, sien_mux_reg, 4'h0};
  wire logic [31:0] rd_irq_persistence = {28'h0, irq_persistence_reg};
  wire logic [31:0] rd_st   = {29'h0, status_reg};
  wire logic [31:0] rd_mask = {29'h0, mask_reg};
  wire logic [31:0] rd_low  = {16'h0, low_th_reg};
  wire logic [31:0] rd_high = {16'h0, high_th_reg};
  wire logic [31:0] rd_ctrl = {27'h0, kick_reg, ch_sel_reg, sp_en_reg};

  // Unmapped addresses read as zero
  wire logic [31:0] rd_word = ({32{sel_mux}}  & rd_mux)  | ({32{sel_sien}} & rd_sien) |
                              ({32{sel_irq_persistence}} & rd_irq_persistence) | ({32{sel_st}}   & rd_st)   |
                              ({32{sel_mask}} & rd_mask) | ({32{sel_low}}  & rd_low)  |
                              ({32{sel_high}} & rd_high) | ({32{sel_ctrl}} & rd_ctrl);

  // Bus pipeline: writes take no wait, reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg    <= 10'h000;
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      hrdata_reg  <= 32'h00000000;
    end else begin
      if (addr_phase) addr_reg <= haddr[11:2];
      wr_pend_reg <= addr_phase && hwrite;
      rd_wait_reg <= addr_phase && !hwrite;
      if (rd_wait_reg) hrdata_reg <= rd_word;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = !rd_wait_reg;
  assign hresp     = 1'b0;

  // Threshold channel selection
  wire logic [2:0]  ch_idx = (ch_sel_reg < 3'(sipm_pkg::NUM_CH)) ? ch_sel_reg : 3'h0;
  wire logic [15:0] ch_data = sample.ch[ch_idx];

  // Events
  wire logic flicker_change = (flicker_status != flicker_prev_reg);
  wire logic set_mux_done   = mux_done && sien_mux_reg;
  wire logic set_flicker    = flicker_change && flicker_change_irq_enable_reg;
  wire logic [2:0] status_set = {irq_persistence_irq, set_flicker, set_mux_done};
  wire logic [2:0] status_clr = wr_st ? hwdata[2:0] : 3'h0;

  // Set wins over a write-one clear in the same cycle
  assign status_next = (status_reg & ~status_clr) | status_set;

  // Kick stays set until the command finishes
  assign kick_next = (kick_reg && !mux_done) ||
                     (wr_ctrl && hwdata[sipm_pkg::CTRL_KICK_BIT]);

  // Persistence count restarts on disable or rewrite
  wire logic irq_persistence_clear = !sp_en_reg || wr_irq_persistence;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mux_cmd_reg <= sipm_pkg::MUX_CMD_RESET;
    end else if (wr_mux) begin
      mux_cmd_reg <= hwdata[sipm_pkg::MUX_CMD_MSB:sipm_pkg::MUX_CMD_LSB];
    end
  end

  // Interrupt enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sien_mux_reg <= 1'b0;
      flicker_change_irq_enable_reg  <= 1'b0;
    end else if (wr_sien) begin
      sien_mux_reg <= hwdata[sipm_pkg::SIEN_MUX_BIT];
      flicker_change_irq_enable_reg  <= hwdata[sipm_pkg::FLICKER_CHANGE_IRQ_ENABLE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_persistence_reg <= sipm_pkg::IRQ_PERSISTENCE_RESET;
    end else if (wr_irq_persistence) begin
      irq_persistence_reg <= hwdata[sipm_pkg::IRQ_PERSISTENCE_MSB:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= 3'h0;
    end else if (wr_mask) begin
      mask_reg <= hwdata[2:0];
    end
  end

  // Threshold window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_th_reg <= sipm_pkg::LOW_TH_RESET;
    end else if (wr_low) begin
      low_th_reg <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_th_reg <= sipm_pkg::HIGH_TH_RESET;
    end else if (wr_high) begin
      high_th_reg <= hwdata[15:0];
    end
  end

  // Spectral enable and channel selector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_en_reg  <= 1'b0;
      ch_sel_reg <= 3'h0;
    end else if (wr_ctrl) begin
      sp_en_reg  <= hwdata[sipm_pkg::CTRL_SP_EN_BIT];
      ch_sel_reg <= hwdata[sipm_pkg::CTRL_CH_MSB:sipm_pkg::CTRL_CH_LSB];
    end
  end

  // Status, kick and flicker history update every cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg       <= 3'h0;
      kick_reg         <= 1'b0;
      flicker_prev_reg <= 1'b0;
    end else begin
      status_reg       <= status_next;
      kick_reg         <= kick_next;
      flicker_prev_reg <= flicker_status;
    end
  end

  assign irq = |(status_reg & mask_reg);

  sipm_mux_seq u_mux_seq (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .kick       (kick_reg),
    .cmd        (mux_cmd_reg),
    .chain_done (matrix_chain_done),
    .mux_cmd    (matrix_cmd),
    .done       (mux_done),
    .busy       (mux_busy)
  );

  sipm_irq_persistence_filter u_irq_persistence (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .sample_valid (sample.valid && sp_en_reg),
    .sample_data  (ch_data),
    .low_th       (low_th_reg),
    .high_th      (high_th_reg),
    .irq_persistence_code    (irq_persistence_reg),
    .clear        (irq_persistence_clear),
    .irq_persistence_irq     (irq_persistence_irq)
  );

  done_sets_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mux_done && sien_mux_reg) |=> status_reg[sipm_pkg::ST_MUX_DONE_BIT])
    else $error("matrix done did not set its status bit");

  done_gated_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(status_reg[sipm_pkg::ST_MUX_DONE_BIT]) |-> $past(mux_done && sien_mux_reg))
    else $error("matrix done status set while disabled");

  flicker_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (flicker_status != flicker_prev_reg && flicker_change_irq_enable_reg) |=> status_reg[1])
    else $error("flicker change did not set its status bit");

  flicker_gated_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(status_reg[sipm_pkg::ST_FLICKER_BIT]) |-> $past(flicker_change_irq_enable_reg))
    else $error("flicker status set while disabled");

  kick_held_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (kick_reg && !mux_done) |=> kick_reg)
    else $error("kick bit dropped before matrix command finished");

  spectral_irq_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_persistence_irq && mask_reg[sipm_pkg::ST_SPECTRAL_BIT]) |=> irq)
    else $error("unmasked spectral event did not raise irq");

  mux_reset_two_a: assert property (@(posedge hclk)
    $rose(hresetn) |-> (mux_cmd_reg == sipm_pkg::MUX_CMD_RESET))
    else $error("matrix command field not at reset value");

  kick_launch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (kick_reg && !mux_busy) |=> mux_busy)
    else $error("kick did not start the sequencer");

  start_after_kick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    matrix_cmd.start |-> $past(kick_reg))
    else $error("matrix command started without kick");

  done_needs_kick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mux_done |-> kick_reg)
    else $error("matrix command finished with kick clear");

  kick_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mux_done && !(wr_ctrl && hwdata[sipm_pkg::CTRL_KICK_BIT])) |=> !kick_reg)
    else $error("kick bit not cleared at command end");

  mux_write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mux |=>
      (mux_cmd_reg == $past(hwdata[sipm_pkg::MUX_CMD_MSB:sipm_pkg::MUX_CMD_LSB])))
    else $error("matrix command field write lost");

  no_reserved_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
    matrix_cmd.start |-> ($past(mux_cmd_reg) != sipm_pkg::CMD_RESERVED))
    else $error("strobe issued for reserved command code");

  done_w1c_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_st && hwdata[sipm_pkg::ST_MUX_DONE_BIT] && !set_mux_done) |=>
      !status_reg[sipm_pkg::ST_MUX_DONE_BIT])
    else $error("matrix done status not cleared by write");

  flicker_w1c_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_st && hwdata[sipm_pkg::ST_FLICKER_BIT] && !set_flicker) |=>
      !status_reg[sipm_pkg::ST_FLICKER_BIT])
    else $error("flicker status not cleared by write");

  sien_write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_sien |=> (sien_mux_reg == $past(hwdata[sipm_pkg::SIEN_MUX_BIT])) &&
                (flicker_change_irq_enable_reg == $past(hwdata[sipm_pkg::FLICKER_CHANGE_IRQ_ENABLE_BIT])))
    else $error("interrupt enable write lost");

  spectral_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_persistence_irq |=> status_reg[sipm_pkg::ST_SPECTRAL_BIT])
    else $error("spectral event did not set its status bit");

  spectral_gated_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(status_reg[sipm_pkg::ST_SPECTRAL_BIT]) |-> $past(irq_persistence_irq))
    else $error("spectral status set without event");

  ctrl_write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=>
      (ch_sel_reg == $past(hwdata[sipm_pkg::CTRL_CH_MSB:sipm_pkg::CTRL_CH_LSB])))
    else $error("threshold channel selector write lost");

  irq_persistence_write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_irq_persistence |=> (irq_persistence_reg == $past(hwdata[sipm_pkg::IRQ_PERSISTENCE_MSB:0])))
    else $error("persistence field write lost");

endmodule : sipm_top
